// ### src/ewe_pkg.sv
// shared constants and carrier types for the eee wake error register slice
package ewe_pkg;

	localparam int NPORT = 2;
	localparam logic [3:0] PORT_FIRST = 4'h3;
	localparam logic [3:0] PORT_LAST = 4'h4;

	// byte-wide indirect access window
	localparam logic [7:0] ADDR_SEL = 8'h6e;
	localparam logic [7:0] ADDR_OFF = 8'h6f;
	localparam logic [7:0] ADDR_DATA = 8'ha0;
	localparam logic [2:0] TBL_EEE = 3'h1;

	// byte offsets inside the per-port eee register space
	localparam logic [7:0] OFF_CAP_HI = 8'h28;
	localparam logic [7:0] OFF_CAP_LO = 8'h29;
	localparam logic [7:0] OFF_CNT_HI = 8'h2a;
	localparam logic [7:0] OFF_CNT_LO = 8'h2b;

	localparam int CAP_BIT = 1;
	localparam logic CAP_RST = 1'b1;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;

	// timing: wake error threshold 20.5 us, kept in ns
	localparam int CLK_PERIOD_NS = 8;
	localparam int WAKE_THR_NS = 20500;
	localparam logic [15:0] WAKE_THR_CYC = 16'(WAKE_THR_NS / CLK_PERIOD_NS);

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ewe_req_t;

	typedef struct packed {
		logic [2:0] tbl;
		logic fill;
		logic [3:0] port;
	} ewe_sel_t;

	typedef struct packed {
		logic cap;
		logic [15:0] cnt;
		logic [7:0] shadow;
		logic waking;
		logic [15:0] wcnt;
		logic lpi_prev;
	} ewe_port_t;

	typedef struct packed {
		ewe_sel_t sel;
		logic [7:0] off;
		logic [15:0] thr;
		logic [7:0] rdata;
		ewe_port_t [NPORT-1:0] port;
	} ewe_state_t;

endpackage

// ### src/ewe_regs.sv
// per-port eee capability bit and wake-up error counter behind the indirect window
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - capability bit 1, read/write, resets set
// - count each qualifying wake by exactly one
// - wake counts only if longer than threshold
// - default threshold is 20.5 microseconds
// - reading counter clears it; resets zero
// - select port 3 or 4; counter high 0x2a
// - selected byte appears at data address 0xa0
module ewe_regs import ewe_pkg::*; (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire ewe_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [NPORT-1:0] lpi_i,
	input wire logic [NPORT-1:0] idle_i,
	input wire logic thr_wr_i,
	input wire logic [15:0] thr_cyc_i,
	output logic [NPORT-1:0] cap_o
);

	logic [1:0] rst_sync_q;
	logic rst_n;
	ewe_state_t s_q;
	ewe_state_t s_d;
	logic sel_ok;
	logic pidx;
	logic [NPORT-1:0] err_evt;
	logic [NPORT-1:0] clr_evt;

	//////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		err_evt = '0;
		clr_evt = '0;
		sel_ok = (s_q.sel.tbl == TBL_EEE) && ((s_q.sel.port == PORT_FIRST) || (s_q.sel.port == PORT_LAST));
		pidx = (s_q.sel.port == PORT_LAST);
		if (thr_wr_i) begin
			s_d.thr = thr_cyc_i;
		end
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				ADDR_SEL: begin
					s_d.sel = reg_req_i.wdata;
				end
				ADDR_OFF: begin
					s_d.off = reg_req_i.wdata;
				end
				ADDR_DATA: begin
					if (sel_ok && s_q.off == OFF_CAP_LO) begin
						s_d.port[pidx].cap = reg_req_i.wdata[CAP_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				ADDR_SEL: begin
					s_d.rdata = s_q.sel;
				end
				ADDR_OFF: begin
					s_d.rdata = s_q.off;
				end
				ADDR_DATA: begin
					s_d.rdata = 8'h00;
					if (sel_ok) begin
						case (s_q.off)
							OFF_CAP_LO: begin
								s_d.rdata = {6'h00, s_q.port[pidx].cap, 1'b0};
							end
							OFF_CNT_HI: begin
								// low byte is frozen so the pair reads coherently
								s_d.rdata = s_q.port[pidx].cnt[15:8];
								s_d.port[pidx].shadow = s_q.port[pidx].cnt[7:0];
								clr_evt[pidx] = 1'b1;
							end
							OFF_CNT_LO: begin
								s_d.rdata = s_q.port[pidx].shadow;
							end
							default: begin
							end
						endcase
					end
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end
		for (int i = 0; i < NPORT; i++) begin
			s_d.port[i].lpi_prev = lpi_i[i];
			if (s_q.port[i].waking) begin
				if (idle_i[i]) begin
					s_d.port[i].waking = 1'b0;
					err_evt[i] = (s_q.port[i].wcnt > s_q.thr);
				end else if (s_q.port[i].wcnt != CNT_MAX) begin
					s_d.port[i].wcnt = s_q.port[i].wcnt + 16'h0001;
				end
			end
			if (s_q.port[i].lpi_prev && !lpi_i[i]) begin
				s_d.port[i].waking = 1'b1;
				s_d.port[i].wcnt = 16'h0000;
			end
			// the event applies after the clear so a coincident error is kept
			if (clr_evt[i]) begin
				s_d.port[i].cnt = CNT_RST;
			end
			if (err_evt[i] && s_d.port[i].cnt != CNT_MAX) begin
				s_d.port[i].cnt = s_d.port[i].cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.thr <= WAKE_THR_CYC;
			for (int i = 0; i < NPORT; i++) begin
				s_q.port[i].cap <= CAP_RST;
				s_q.port[i].cnt <= CNT_RST;
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o = s_q.rdata;
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			cap_o[i] = s_q.port[i].cap;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// checks
	logic thr_prog_q;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			thr_prog_q <= 1'b0;
		end else if (thr_wr_i) begin
			thr_prog_q <= 1'b1;
		end
	end

	sequence sel_write_s;
		reg_req_i.wr && reg_req_i.addr == ADDR_SEL;
	endsequence

	sequence bad_data_read_s;
		reg_req_i.rd && reg_req_i.addr == ADDR_DATA && !sel_ok;
	endsequence

	AST_THR_DEFAULT: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!thr_prog_q |-> s_q.thr == WAKE_THR_CYC)
		else $error("wake threshold left default value without programming");

	AST_SEL_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		sel_write_s |=> s_q.sel == $past(reg_req_i.wdata))
		else $error("select register did not take written value");

	AST_BAD_SEL_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		bad_data_read_s |=> reg_rdata_o == 8'h00)
		else $error("data window not zero for invalid selection");

	for (genvar g = 0; g < NPORT; g++) begin : g_chk
		AST_CAP_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			reg_req_i.wr && reg_req_i.addr == ADDR_DATA && sel_ok && pidx == g && s_q.off == OFF_CAP_LO
			|=> cap_o[g] == $past(reg_req_i.wdata[CAP_BIT]))
			else $error("capability bit did not follow write");

		AST_CNT_STEP: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			err_evt[g] && !clr_evt[g] && s_q.port[g].cnt != CNT_MAX
			|=> s_q.port[g].cnt == $past(s_q.port[g].cnt) + 16'h0001)
			else $error("counter did not step by one on wake error");

		AST_NO_SPURIOUS: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			!err_evt[g] |=> s_q.port[g].cnt == $past(s_q.port[g].cnt) || $past(clr_evt[g]) && s_q.port[g].cnt == 16'h0000)
			else $error("counter rose without a qualifying wake");

		AST_SHORT_WAKE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			s_q.port[g].waking && idle_i[g] && s_q.port[g].wcnt <= s_q.thr |-> !err_evt[g])
			else $error("short wake flagged as error");

		AST_READ_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			clr_evt[g] ##0 !err_evt[g] |=> s_q.port[g].cnt == 16'h0 ##1 s_q.port[g].cnt <= 16'h0001)
			else $error("counter not cleared by read");

		AST_SATURATE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			s_q.port[g].cnt == CNT_MAX && !clr_evt[g] |=> s_q.port[g].cnt == CNT_MAX)
			else $error("counter wrapped past all ones");

		// a long wake that ends in the cycle of a clearing read must still leave one count behind
		AST_LONG_WAKE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			s_q.port[g].waking && idle_i[g] && s_q.port[g].wcnt > s_q.thr && (s_q.port[g].cnt != CNT_MAX || clr_evt[g])
			|=> s_q.port[g].cnt == ($past(clr_evt[g]) ? 16'h0001 : $past(s_q.port[g].cnt) + 16'h0001))
			else $error("long wake not counted once");

		AST_WAKE_START: assert property (@(posedge core_clk_i) disable iff (!rst_n)
			s_q.port[g].lpi_prev && !lpi_i[g] |=> s_q.port[g].waking && s_q.port[g].wcnt == 16'h0000)
			else $error("wake measurement did not start at low power exit");
	end

	// the read data must not drift between reads, software may sample it late
	AST_RDATA_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!reg_req_i.rd |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");

	if (1) begin : g_pad
	end

endmodule

// ### test/ewe_regs_tb.sv
// self-checking bench for the eee wake error register slice
`timescale 1ns/1ns
module tb import ewe_pkg::*;;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic thr_wr_i = 1'b0;
	logic [15:0] thr = 16'h0000;
	logic [1:0] lpi = 2'h0;
	logic [1:0] idle = 2'h0;
	ewe_req_t req = '0;
	logic [7:0] rdata;
	logic [1:0] cap;
	int failures = 0;
	int checks = 0;

	ewe_regs i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.lpi_i(lpi), .idle_i(idle), .thr_wr_i(thr_wr_i), .thr_cyc_i(thr), .cap_o(cap));

	initial forever #4 core_clk_i = ~core_clk_i;

	//////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge core_clk_i);
		req.wr = 1'b0;
	endtask

	// read data is judged a full cycle late; it holds until the next read anyway
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk_i);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge core_clk_i);
		req.rd = 1'b0;
		@(negedge core_clk_i);
		chk(rdata, exp);
	endtask

	task automatic sel(input logic [7:0] s, input logic [7:0] o);
		wr(ADDR_SEL, s);
		wr(ADDR_OFF, o);
	endtask

	// lpi falls, idle stays low for n counted cycles, then idle arrives
	task automatic wake(input int p, input int n);
		@(negedge core_clk_i);
		lpi[p] = 1'b1;
		@(negedge core_clk_i);
		lpi[p] = 1'b0;
		repeat (n + 1) @(negedge core_clk_i);
		idle[p] = 1'b1;
		@(negedge core_clk_i);
		idle[p] = 1'b0;
		repeat (2) @(negedge core_clk_i);
	endtask

	//////////////////////////////////////////////////////////////////////////////
	task automatic t_refuse;
		sel(8'h43, OFF_CAP_LO);
		rd(ADDR_SEL, 8'h43);
		wr(ADDR_DATA, 8'h00);
		rd(ADDR_DATA, 8'h00);
		sel(8'h25, OFF_CAP_LO);
		rd(ADDR_OFF, OFF_CAP_LO);
		rd(ADDR_DATA, 8'h00);
		rd(ADDR_SEL, 8'h25);
		rd(8'h10, 8'h00);
	endtask

	task automatic t_cap;
		chk({6'h00, cap}, 8'h03);
		sel(8'h23, OFF_CAP_LO);
		rd(ADDR_DATA, 8'h02);
		wr(ADDR_DATA, 8'hfd);
		chk({6'h00, cap}, 8'h02);
		rd(ADDR_DATA, 8'h00);
		wr(ADDR_DATA, 8'h02);
		chk({6'h00, cap}, 8'h03);
		sel(8'h24, OFF_CAP_LO);
		rd(ADDR_DATA, 8'h02);
	endtask

	task automatic t_default;
		wake(1, WAKE_THR_CYC);
		wake(1, WAKE_THR_CYC + 16'h0001);
		sel(8'h24, OFF_CNT_HI);
		rd(ADDR_DATA, 8'h00);
		wr(ADDR_OFF, OFF_CNT_LO);
		rd(ADDR_DATA, 8'h01);
	endtask

	task automatic t_thr;
		@(negedge core_clk_i);
		thr = 16'h000a;
		thr_wr_i = 1'b1;
		@(negedge core_clk_i);
		thr_wr_i = 1'b0;
		wake(0, 10);
		wake(0, 11);
		wake(0, 11);
		sel(8'h23, OFF_CNT_HI);
		rd(ADDR_DATA, 8'h00);
		wr(ADDR_OFF, OFF_CNT_LO);
		rd(ADDR_DATA, 8'h02);
		wr(ADDR_OFF, OFF_CNT_HI);
		rd(ADDR_DATA, 8'h00);
		wr(ADDR_OFF, OFF_CNT_LO);
		rd(ADDR_DATA, 8'h00);
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge core_clk_i);
		rstn_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		t_refuse();
		t_cap();
		t_default();
		t_thr();
		end_sim();
	end
endmodule
